// ===== ieee488_status_reporting_tb.sv
// self-checking bench of the status reporting block
`timescale 1ns/1ns
module ieee488_status_reporting_tb;
    import isr_pkg::*;
    logic mclk_in = 0, rst_n_in = 0, psc_in = 1, cmd_valid_in = 0, cmd_sel_in = 0;
    logic cmd_first_in = 0, err_push_in = 0, mav_in = 0, dcl_in = 0, pp_go = 0, sp_go = 0;
    logic [7:0] saved_sre_in = 8'hA5, saved_ese_in = 8'h00, saved_ppe_in = 8'h00;
    logic [7:0] esr_evt_in = 8'h00, dio_out, dio_oe_out, spoll_byte_out;
    logic [15:0] cmd_data_in = 0, err_code_in = 0, oper_cond_in = 0, grpa_cond_in = 0;
    logic [15:0] rsp_data_out;
    logic ppoll_in, spoll_req_in, srq_out, spoll_valid_out, rsp_valid_out;
    logic flush_out, abort_out, settings_rst_out;
    isr_op_t cmd_op_in = OP_NONE;
    int bad_count = 0, num_checks = 0, cycles = 0;
    always #50 mclk_in = ~mclk_in;
    isr_status dut (.*);
    isr_bus_ctrl ctrl (.clk_in(mclk_in), .pp_go_in(pp_go), .sp_go_in(sp_go),
        .ppoll_out(ppoll_in), .spoll_out(spoll_req_in));
    task automatic chk(input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin bad_count++; $display("[FAIL] %0t %h %h", $time, got, exp); end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : tick
    task automatic cmd(input isr_op_t op, logic [15:0] d = 0, logic sel = 0, first = 0);
        @(posedge mclk_in);
        {cmd_valid_in, cmd_sel_in, cmd_first_in, cmd_data_in} <= {1'b1, sel, first, d};
        cmd_op_in <= op;
        @(posedge mclk_in) cmd_valid_in <= 0;
        #1;
    endtask : cmd
    task automatic rd(input isr_op_t op, logic [15:0] exp, logic sel = 0);
        cmd(op, 16'h0000, sel);
        chk(rsp_valid_out ? rsp_data_out : 16'hDEAD, exp);
    endtask : rd
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    always @(posedge mclk_in) if (++cycles == 3000) begin bad_count++; print_verdict(); end
    initial begin
        repeat (5) @(posedge mclk_in);
        rst_n_in <= 1;
        tick(3);
        rd(OP_RD_SRE, 16'h0000);
        rd(OP_RD_ESR, 16'h0000);
        cmd(OP_WR_ESE, 16'h0001);
        cmd(OP_WR_SRE, 16'h0020);
        cmd(OP_WR_PPE, 16'h0020);
        cmd(OP_PPC, 16'h000B);
        @(posedge mclk_in) esr_evt_in <= 8'h01;
        @(posedge mclk_in) esr_evt_in <= 8'h00;
        tick(3);
        chk(16'(srq_out), 16'h0001);
        rd(OP_RD_STB, 16'h0060);
        rd(OP_RD_IST, 16'h0001);
        @(posedge mclk_in) pp_go <= 1;
        @(posedge mclk_in) pp_go <= 0;
        tick(2);
        chk({dio_oe_out, dio_out & dio_oe_out}, 16'h0808);
        cmd(OP_PPU);
        @(posedge mclk_in) pp_go <= 1;
        @(posedge mclk_in) pp_go <= 0;
        tick(2);
        chk({dio_oe_out, dio_out}, 16'h00FF);
        @(posedge mclk_in) sp_go <= 1;
        @(posedge mclk_in) sp_go <= 0;
        tick(1);
        chk({srq_out, spoll_valid_out, 6'h00, spoll_byte_out}, 16'h4060);
        rd(OP_RD_ESR, 16'h0001);
        rd(OP_RD_ESR, 16'h0000);
        @(posedge mclk_in) {err_push_in, err_code_in, mav_in} <= {1'b1, 16'h0071, 1'b1};
        @(posedge mclk_in) err_code_in <= 16'h0072;
        @(posedge mclk_in) err_push_in <= 0;
        tick(2);
        rd(OP_RD_STB, 16'h0014);
        rd(OP_RD_ERR, 16'h0071);
        rd(OP_RD_ERR, 16'h0072);
        rd(OP_RD_ERR, 16'h0000);
        cmd(OP_WR_EN, 16'h0001, 1'b1);
        @(posedge mclk_in) grpa_cond_in <= 16'h0001;
        tick(3);
        rd(OP_RD_STB, 16'h0018);
        rd(OP_RD_EVENT, 16'h0001, 1'b1);
        rd(OP_RD_EVENT, 16'h0000, 1'b1);
        rd(OP_RD_COND, 16'h0001, 1'b1);
        cmd(OP_WR_FALL, 16'h0001, 1'b1);
        cmd(OP_WR_RISE, 16'h0000, 1'b1);
        @(posedge mclk_in) grpa_cond_in <= 16'h0000;
        tick(2);
        rd(OP_RD_EVENT, 16'h0001, 1'b1);
        cmd(OP_STAT_PRE);
        rd(OP_RD_EN, 16'h0000, 1'b1);
        @(posedge mclk_in) grpa_cond_in <= 16'h0001;
        tick(2);
        rd(OP_RD_EVENT, 16'h0001, 1'b1);
        @(posedge mclk_in) grpa_cond_in <= 16'h0000;
        tick(2);
        rd(OP_RD_EVENT, 16'h0000, 1'b1);
        @(posedge mclk_in) esr_evt_in <= 8'h01;
        @(posedge mclk_in) esr_evt_in <= 8'h00;
        cmd(OP_CLS);
        rd(OP_RD_ESR, 16'h0000);
        rd(OP_RD_SRE, 16'h0020);
        rd(OP_RD_ESE, 16'h0001);
        rd(OP_RD_PPE, 16'h0020);
        cmd(OP_RST);
        chk(16'(settings_rst_out), 16'h0001);
        cmd(OP_SYS_PRE);
        chk(16'(settings_rst_out), 16'h0001);
        cmd(OP_RD_STB, 16'h0000, 1'b0, 1'b1);
        chk(16'(flush_out), 16'h0001);
        @(posedge mclk_in) dcl_in <= 1;
        @(posedge mclk_in) dcl_in <= 0;
        tick(0);
        chk({settings_rst_out, abort_out, flush_out}, 16'h0003);
        // second power-up with the clear flag low: masks come back from the saved copies
        @(posedge mclk_in) {rst_n_in, psc_in} <= 2'b00;
        repeat (5) @(posedge mclk_in);
        rst_n_in <= 1;
        tick(1);
        chk({abort_out, flush_out}, 16'h0003);
        rd(OP_RD_SRE, 16'h00A5);
        print_verdict();
    end
endmodule : ieee488_status_reporting_tb

// ===== isr_bus_ctrl.sv
// bus controller model: serial and parallel poll timing
`timescale 1ns/1ns
module isr_bus_ctrl (
    input  wire logic clk_in,
    input  wire logic pp_go_in,
    input  wire logic sp_go_in,
    output logic      ppoll_out,
    output logic      spoll_out
);
    logic [2:0] cnt_q = 3'h0; // cycles left of the parallel poll
    // one command polls all devices at once for five cycles
    always_ff @(posedge clk_in) cnt_q <= pp_go_in ? 3'h5 : cnt_q - 3'(cnt_q != 3'h0);
    always_ff @(posedge clk_in) spoll_out <= sp_go_in;
    assign ppoll_out = cnt_q != 3'h0;
endmodule : isr_bus_ctrl

// ===== isr_errq.sv
// error queue: flip-flop fifo of error codes
`timescale 1ns/1ns
module isr_errq (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    isr_errq_if.queue  q
);
    import isr_pkg::*;

    logic [15:0]        mem_q [ERRQ_DEPTH];   // stored codes
    logic [ERRQ_AW-1:0] rd_q;                 // oldest entry index
    logic [ERRQ_AW-1:0] wr_q;                 // next free index
    logic [ERRQ_CW-1:0] cnt_q;                // entries held
    logic               do_push;              // push accepted
    logic               do_pop;               // pop accepted

    // a full queue drops new codes; a pop frees room in the same cycle
    assign do_pop  = q.pop && (cnt_q != '0);
    assign do_push = q.push && ((cnt_q != ERRQ_CW'(ERRQ_DEPTH)) || do_pop);

    // empty queue answers with the no-error code
    assign q.head     = (cnt_q != '0) ? mem_q[rd_q] : ERR_NONE;
    assign q.nonempty = (cnt_q != '0);

    // storage writes; a push during clear lands in entry 0
    always_ff @(posedge clk_in) begin
        if (q.clear && q.push) begin
            mem_q[0] <= q.code;
        end else if (!q.clear && do_push) begin
            mem_q[wr_q] <= q.code;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end else if (q.clear) begin
            // an error arriving with the clear is kept
            rd_q  <= '0;
            wr_q  <= q.push ? ERRQ_AW'(1) : '0;
            cnt_q <= q.push ? ERRQ_CW'(1) : '0;
        end else begin
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            cnt_q <= cnt_q + ERRQ_CW'(do_push) - ERRQ_CW'(do_pop);
        end
    end

endmodule : isr_errq

// ===== isr_errq_if.sv
// signals between the status core and its error queue
`timescale 1ns/1ns
interface isr_errq_if;
    logic        push;      // store one error code
    logic [15:0] code;      // code to store
    logic        pop;       // remove the oldest entry
    logic        clear;     // empty the queue
    logic [15:0] head;      // oldest entry, or the no-error code
    logic        nonempty;  // at least one entry held

    modport core  (output push, output code, output pop, output clear,
                   input head, input nonempty);
    modport queue (input push, input code, input pop, input clear,
                   output head, output nonempty);
endinterface : isr_errq_if

// ===== isr_pkg.sv
// shared constants and types of the status reporting block
package isr_pkg;

    localparam int STB_W      = 8;                  // status byte and event status width
    localparam int SCPI_W     = 16;                 // width of every scpi-level register
    localparam int NUM_SCPI   = 2;                  // operation and group_a registers
    localparam int ERRQ_DEPTH = 8;                  // entries held by the error queue
    localparam int ERRQ_AW    = 3;                  // index width of the error queue
    localparam int ERRQ_CW    = 4;                  // fill count width of the error queue

    // status byte bit positions
    localparam int STB_ERRQ_BIT = 2;                // error queue not empty
    localparam int STB_GRPA_BIT = 3;                // group_a summary
    localparam int STB_MAV_BIT  = 4;                // output buffer holds a message
    localparam int STB_ESB_BIT  = 5;                // event_summary_bit
    localparam int STB_MSS_BIT  = 6;                // master summary / request bit
    localparam int STB_OPER_BIT = 7;                // operation summary
    localparam int ESR_OPC_BIT  = 0;                // operation complete in event_status

    localparam logic [7:0]  SRQ_SRC_MASK  = 8'hBC;  // bits 2,3,4,5,7 may raise a request
    localparam logic [7:0]  MASK_RST      = 8'h00;  // cleared enable mask value
    localparam logic [15:0] EN_PRESET     = 16'h0000; // preset enable of operation/group_a
    localparam logic [15:0] RISE_PRESET   = 16'hFFFF; // preset rise_filter value
    localparam logic [15:0] FALL_PRESET   = 16'h0000; // preset fall_filter value
    localparam logic [15:0] SCPI_USE_MASK = 16'h7FFF; // bit 15 always reads 0
    localparam logic [15:0] ERR_NONE      = 16'h0000; // code returned by an empty queue

    localparam int SCPI_OPER = 0;                   // index of the operation register
    localparam int SCPI_GRPA = 1;                   // index of the group_a register

    // parallel poll configuration field positions within cmd_data
    localparam int PPC_LINE_LSB = 0;                // data line number, 3 bits
    localparam int PPC_SENSE_BIT = 3;               // response sense

    // commands accepted on the command port
    typedef enum logic [4:0] {
        OP_NONE     = 5'h00,
        OP_RD_STB   = 5'h01,
        OP_RD_ESR   = 5'h02,
        OP_WR_ESE   = 5'h03,
        OP_RD_ESE   = 5'h04,
        OP_WR_SRE   = 5'h05,
        OP_RD_SRE   = 5'h06,
        OP_WR_PPE   = 5'h07,
        OP_RD_PPE   = 5'h08,
        OP_RD_IST   = 5'h09,
        OP_CLS      = 5'h0A,
        OP_RST      = 5'h0B,
        OP_SYS_PRE  = 5'h0C,
        OP_STAT_PRE = 5'h0D,
        OP_RD_COND  = 5'h0E,
        OP_RD_EVENT = 5'h0F,
        OP_WR_EN    = 5'h10,
        OP_RD_EN    = 5'h11,
        OP_WR_RISE  = 5'h12,
        OP_WR_FALL  = 5'h13,
        OP_RD_ERR   = 5'h14,
        OP_PPC      = 5'h15,
        OP_PPU      = 5'h16
    } isr_op_t;

    // power-up sequencing, one-hot
    typedef enum logic [1:0] {
        ST_POR = 2'b01,
        ST_RUN = 2'b10
    } isr_state_t;

endpackage : isr_pkg

// ===== isr_status.sv
// status byte, event status, scpi registers, polls and reset matrix
`timescale 1ns/1ns
module isr_status (
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire logic             psc_in,          // power-on-status-clear flag
    input  wire logic [7:0]       saved_sre_in,    // retained request mask
    input  wire logic [7:0]       saved_ese_in,    // retained event mask
    input  wire logic [7:0]       saved_ppe_in,    // retained poll mask
    input  wire logic             cmd_valid_in,    // command strobe
    input  wire isr_pkg::isr_op_t cmd_op_in,       // command code
    input  wire logic             cmd_sel_in,      // scpi register select
    input  wire logic [15:0]      cmd_data_in,     // write data
    input  wire logic             cmd_first_in,    // first command after terminator
    input  wire logic [7:0]       esr_evt_in,      // event_status set pulses
    input  wire logic [15:0]      oper_cond_in,    // operation condition
    input  wire logic [15:0]      grpa_cond_in,    // group_a condition
    input  wire logic             err_push_in,     // error occurred
    input  wire logic [15:0]      err_code_in,     // its code
    input  wire logic             mav_in,          // output buffer holds data
    input  wire logic             dcl_in,          // device clear pulse
    input  wire logic             spoll_req_in,    // serial poll pulse
    input  wire logic             ppoll_in,        // parallel poll in progress
    output logic                  srq_out,         // service request
    output logic                  spoll_valid_out, // serial poll answer strobe
    output logic [7:0]            spoll_byte_out,  // serial poll status byte
    output logic [7:0]            dio_out,         // poll data lines
    output logic [7:0]            dio_oe_out,      // poll line drive enables
    output logic                  rsp_valid_out,   // query answer strobe
    output logic [15:0]           rsp_data_out,    // query answer value
    output logic                  flush_out,       // empty output buffer
    output logic                  abort_out,       // empty input, stop parsing
    output logic                  settings_rst_out // reset instrument settings
);
    import isr_pkg::*;

    isr_errq_if eq ();                             // error queue link

    isr_state_t         state_q;                   // power-up sequencing
    logic [7:0]         esr_q;                     // event_status
    logic [7:0]         ese_q;                     // event_status_enable
    logic [7:0]         sre_q;                     // service_request_enable
    logic [7:0]         ppe_q;                     // parallel_poll_enable
    logic [SCPI_W-1:0]  prev_q  [NUM_SCPI];        // last sampled condition
    logic [SCPI_W-1:0]  event_q [NUM_SCPI];        // event parts
    logic [SCPI_W-1:0]  en_q    [NUM_SCPI];        // enable parts
    logic [SCPI_W-1:0]  rise_q  [NUM_SCPI];        // rise_filter parts
    logic [SCPI_W-1:0]  fall_q  [NUM_SCPI];        // fall_filter parts
    logic [SCPI_W-1:0]  cond    [NUM_SCPI];        // live conditions
    logic [NUM_SCPI-1:0] sum;                      // scpi summaries
    logic               mss_prev_q;                // mss last cycle
    logic               rqs_q;                     // request latch
    logic               flush_arm_q;               // flush on next line
    logic               ppc_en_q;                  // poll answer configured
    logic [2:0]         ppc_line_q;                // assigned data line
    logic               ppc_sense_q;               // answer polarity
    logic [7:0]         stb;                       // status byte, bit 6 = mss
    logic               event_summary_bit;                       // event_summary_bit
    logic               mss;                       // master summary
    logic               ist;                       // individual status
    logic               por;                       // power-up cycle
    logic               por_clr;                   // power-up with flag at 1
    logic               cls;                       // clear-status
    logic               spre;                      // status preset

    // true when a command of the given code is presented
    function automatic logic hit(input isr_op_t op);
        return cmd_valid_in && (cmd_op_in == op);
    endfunction : hit

    assign por     = (state_q == ST_POR);
    assign por_clr = por && psc_in;
    assign cls     = hit(OP_CLS);
    assign spre    = hit(OP_STAT_PRE) || por_clr;
    assign cond[SCPI_OPER] = oper_cond_in & SCPI_USE_MASK;
    assign cond[SCPI_GRPA] = grpa_cond_in & SCPI_USE_MASK;

    // status byte assembly and request condition
    assign event_summary_bit = |(esr_q & ese_q);
    always_comb begin
        stb               = '0;
        stb[STB_ERRQ_BIT] = eq.nonempty;
        stb[STB_GRPA_BIT] = sum[SCPI_GRPA];
        stb[STB_MAV_BIT]  = mav_in;
        stb[STB_ESB_BIT]  = event_summary_bit;
        stb[STB_OPER_BIT] = sum[SCPI_OPER];
        stb[STB_MSS_BIT]  = |(stb & sre_q & SRQ_SRC_MASK);
    end
    assign mss = stb[STB_MSS_BIT];
    assign ist = |(stb & ppe_q);

    // power-up sequencing: one cycle to take the flag, then run
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ST_POR;
        end else begin
            unique case (state_q)
                ST_POR: begin
                    state_q <= ST_RUN;
                end
                ST_RUN: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // scpi registers: transition filters, event, enable
    for (genvar g = 0; g < NUM_SCPI; g++) begin : g_scpi
        logic [SCPI_W-1:0] hit_evt;                  // filtered transitions
        logic              rd_clr;                   // event read of this register
        assign hit_evt = (cond[g] & ~prev_q[g] & rise_q[g])
                       | (~cond[g] & prev_q[g] & fall_q[g]);
        assign rd_clr  = hit(OP_RD_EVENT) && (cmd_sel_in == 1'(g));
        assign sum[g]  = |(event_q[g] & en_q[g]);

        always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                prev_q[g]  <= '0;
                event_q[g] <= '0;
            end else begin
                prev_q[g] <= cond[g];
                // new transitions win over a clear in the same cycle
                if (rd_clr || cls || por_clr) begin
                    event_q[g] <= hit_evt;
                end else begin
                    event_q[g] <= event_q[g] | hit_evt;
                end
            end
        end

        // enable and filter parts; preset wins over a write
        always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                en_q[g]   <= EN_PRESET;
                rise_q[g] <= RISE_PRESET;
                fall_q[g] <= FALL_PRESET;
            end else if (spre) begin
                en_q[g]   <= EN_PRESET;
                rise_q[g] <= RISE_PRESET;
                fall_q[g] <= FALL_PRESET;
            end else if (cmd_sel_in == 1'(g)) begin
                if (hit(OP_WR_EN)) begin
                    en_q[g] <= cmd_data_in & SCPI_USE_MASK;
                end
                if (hit(OP_WR_RISE)) begin
                    rise_q[g] <= cmd_data_in & SCPI_USE_MASK;
                end
                if (hit(OP_WR_FALL)) begin
                    fall_q[g] <= cmd_data_in & SCPI_USE_MASK;
                end
            end
        end
    end

    // event_status: pulses set bits, read or clear-status clears
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            esr_q <= '0;
        end else if (hit(OP_RD_ESR) || cls || por_clr) begin
            esr_q <= esr_evt_in;
        end else begin
            esr_q <= esr_q | esr_evt_in;
        end
    end

    // enable masks: only power-up touches them besides their own writes
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sre_q <= MASK_RST;
            ese_q <= MASK_RST;
            ppe_q <= MASK_RST;
        end else if (por) begin
            sre_q <= psc_in ? MASK_RST : saved_sre_in;
            ese_q <= psc_in ? MASK_RST : saved_ese_in;
            ppe_q <= psc_in ? MASK_RST : saved_ppe_in;
        end else begin
            if (hit(OP_WR_SRE)) begin
                sre_q <= cmd_data_in[7:0];
            end
            if (hit(OP_WR_ESE)) begin
                ese_q <= cmd_data_in[7:0];
            end
            if (hit(OP_WR_PPE)) begin
                ppe_q <= cmd_data_in[7:0];
            end
        end
    end

    // request latch: rises with mss, drops with mss or a serial poll
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mss_prev_q <= 1'b0;
            rqs_q      <= 1'b0;
            srq_out    <= 1'b0;
        end else begin
            mss_prev_q <= mss;
            rqs_q      <= mss && ((!mss_prev_q) || (rqs_q && !spoll_req_in));
            srq_out    <= mss && ((!mss_prev_q) || (rqs_q && !spoll_req_in));
        end
    end

    // serial poll answer: status byte with the request bit
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            spoll_valid_out <= 1'b0;
            spoll_byte_out  <= '0;
        end else begin
            spoll_valid_out <= spoll_req_in;
            if (spoll_req_in) begin
                spoll_byte_out <= {stb[7], rqs_q, stb[5:0]};
            end
        end
    end

    // parallel poll configuration
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ppc_en_q    <= 1'b0;
            ppc_line_q  <= '0;
            ppc_sense_q <= 1'b0;
        end else if (hit(OP_PPC)) begin
            ppc_en_q    <= 1'b1;
            ppc_line_q  <= cmd_data_in[PPC_LINE_LSB +: 3];
            ppc_sense_q <= cmd_data_in[PPC_SENSE_BIT];
        end else if (hit(OP_PPU)) begin
            ppc_en_q <= 1'b0;
        end
    end

    // parallel poll drive: only the assigned line, polarity applied
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dio_out    <= '0;
            dio_oe_out <= '0;
        end else begin
            dio_out    <= {8{ist ~^ ppc_sense_q}};
            dio_oe_out <= (ppoll_in && ppc_en_q) ? (8'h01 << ppc_line_q) : 8'h00;
        end
    end

    // query answers: register contents as plain binary weights
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= '0;
        end else begin
            rsp_valid_out <= 1'b1;
            unique case (cmd_valid_in ? cmd_op_in : OP_NONE)
                OP_RD_STB:   rsp_data_out <= {8'h00, stb};
                OP_RD_ESR:   rsp_data_out <= {8'h00, esr_q};
                OP_RD_ESE:   rsp_data_out <= {8'h00, ese_q};
                OP_RD_SRE:   rsp_data_out <= {8'h00, sre_q};
                OP_RD_PPE:   rsp_data_out <= {8'h00, ppe_q};
                OP_RD_IST:   rsp_data_out <= {15'h0000, ist};
                OP_RD_COND:  rsp_data_out <= cond[cmd_sel_in];
                OP_RD_EVENT: rsp_data_out <= event_q[cmd_sel_in];
                OP_RD_EN:    rsp_data_out <= en_q[cmd_sel_in];
                OP_RD_ERR:   rsp_data_out <= eq.head;
                default: begin
                    rsp_valid_out <= 1'b0;
                end
            endcase
        end
    end

    // error queue hookup: push per error, pop per read, clear on status clear
    assign eq.push  = err_push_in;
    assign eq.code  = err_code_in;
    assign eq.pop   = hit(OP_RD_ERR);
    assign eq.clear = cls || por;

    isr_errq u_errq (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n_in),
        .q        (eq)
    );

    // buffer flushing and settings reset
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flush_arm_q      <= 1'b0;
            flush_out        <= 1'b0;
            abort_out        <= 1'b0;
            settings_rst_out <= 1'b0;
        end else begin
            flush_out <= por || dcl_in
                      || (flush_arm_q && cmd_valid_in && cmd_first_in);
            abort_out <= por || dcl_in;
            settings_rst_out <= hit(OP_RST) || hit(OP_SYS_PRE);
            if (hit(OP_RST) || hit(OP_SYS_PRE) || hit(OP_STAT_PRE) || cls) begin
                flush_arm_q <= 1'b1;
            end else if (cmd_valid_in && cmd_first_in) begin
                flush_arm_q <= 1'b0;
            end
        end
    end

endmodule : isr_status

// ===== isr_status_monitor.sv
// assertions on the status block ports
`timescale 1ns/1ns
module isr_status_mon (
    input wire logic mclk_in, rst_n_in, cmd_valid_in, dcl_in, spoll_req_in, ppoll_in,
    input wire logic srq_out, spoll_valid_out, rsp_valid_out, abort_out, flush_out,
    input wire logic settings_rst_out,
    input wire isr_pkg::isr_op_t cmd_op_in,
    input wire logic [7:0] dio_oe_out,
    input wire logic [15:0] rsp_data_out
);
    import isr_pkg::*;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    AST_RD: assert property (cmd_valid_in && cmd_op_in inside {OP_RD_STB, OP_RD_ESR,
        OP_RD_SRE, OP_RD_IST, OP_RD_ERR} |=> rsp_valid_out) else $error("no answer");
    AST_WR: assert property (cmd_valid_in && cmd_op_in inside {OP_WR_ESE, OP_WR_SRE,
        OP_CLS} |=> !rsp_valid_out) else $error("write answered");
    AST_IST: assert property (rsp_valid_out && $past(cmd_op_in) == OP_RD_IST
        |-> rsp_data_out[15:1] == 15'h0000) else $error("ist not one bit");
    AST_SPOLL: assert property (spoll_req_in |=> spoll_valid_out)
        else $error("serial poll");
    // a poll drops a standing request; a request rising in the poll cycle is a new one
    AST_SPOLL_SRQ: assert property (spoll_req_in && srq_out |=> !srq_out)
        else $error("request kept after serial poll");
    AST_PP_IDLE: assert property (!ppoll_in |=> dio_oe_out == 8'h00)
        else $error("poll line idle");
    AST_PP_ONE: assert property (ppoll_in |=> $onehot0(dio_oe_out))
        else $error("poll lines");
    AST_DCL: assert property (dcl_in |=> abort_out && flush_out)
        else $error("device clear");
    AST_SET: assert property (settings_rst_out |-> $past(cmd_valid_in)
        && $past(cmd_op_in) inside {OP_RST, OP_SYS_PRE}) else $error("settings reset");
endmodule : isr_status_mon
bind isr_status isr_status_mon u_mon (.*);
